/* core/rtw_core.sv */
// Calendar clock support: oscillator control, trim, alarm, watchdog, power fail and interrupt pin.
`timescale 1ns/1ps
module rtw_core
   import rtw_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int CHECK_CYCLES = OSC_CHECK_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [14:0] addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out,
   output logic dq_oe_n,
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic osc_clk,
   input wire logic osc_running,
   input wire logic supply_ok,
   input wire logic [7:0] time_sec,
   input wire logic [7:0] time_min,
   input wire logic [7:0] time_hour,
   input wire logic [7:0] time_date,
   output logic osc_run_en,
   output logic base_time_reload,
   output logic int_out,
   output logic int_oe_n
);
   logic e_s, w_s, g_s, osc_s, run_s, sup_s;
   logic e_d, osc_d, sup_d;
   logic [7:0] trim, intr, dog_load;
   logic [6:0] alarm_sec, alarm_min, alarm_hour, alarm_date;
   logic [3:0] alarm_mask;
   logic osc_fail_flag, alarm_match_flag, dog_timeout_flag, supply_loss_flag;
   logic freq_test, unlock, load_lock;
   logic [7:0] dog_cnt;
   logic [22:0] check_cnt;
   logic checking;
   logic [22:0] pulse_cnt;
   logic int_active;
   logic sec_tick, dog_tick, test_wave;
   logic acc_start, wr_acc, rd_acc, rd_flags;
   logic osc_edge, matched, dog_fire, supply_fall, supply_rise;
   logic [22:0] bus_pins, bus_s;
   logic [14:0] addr_s;
   logic [7:0] din_s;

   rtw_sync u_sync_e (.sys_clk(sys_clk), .reset(reset), .d(~chip_en_n), .q(e_s));
   rtw_sync u_sync_w (.sys_clk(sys_clk), .reset(reset), .d(~write_en_n), .q(w_s));
   rtw_sync u_sync_g (.sys_clk(sys_clk), .reset(reset), .d(~out_en_n), .q(g_s));
   rtw_sync u_sync_o (.sys_clk(sys_clk), .reset(reset), .d(osc_clk), .q(osc_s));
   rtw_sync u_sync_r (.sys_clk(sys_clk), .reset(reset), .d(osc_running), .q(run_s));
   rtw_sync u_sync_p (.sys_clk(sys_clk), .reset(reset), .d(supply_ok), .q(sup_s));

   // Address and data pins pass two flip-flops like the strobes, so all of them settle together.
   assign bus_pins = {addr, dq_in};
   for (genvar i = 0; i < 23; i++) begin : g_bus_sync
      rtw_sync u_sync_b (
         .sys_clk(sys_clk),
         .reset(reset),
         .d(bus_pins[i]),
         .q(bus_s[i])
      );
   end
   assign addr_s = bus_s[22:8];
   assign din_s = bus_s[7:0];

   rtw_trim u_trim (
      .sys_clk(sys_clk),
      .reset(reset),
      .osc_edge(osc_edge),
      .trim(trim),
      .sec_tick(sec_tick),
      .dog_tick(dog_tick),
      .test_wave(test_wave)
   );

   // Edge history of the synchronised enable, oscillator and supply levels.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         e_d <= 1'b0;
         osc_d <= 1'b0;
         sup_d <= 1'b0;
      end else begin
         e_d <= e_s;
         osc_d <= osc_s;
         sup_d <= sup_s;
      end
   end

   // A stopped oscillator produces no edges, so the watchdog freezes with it.
   assign osc_edge = osc_s && !osc_d && !trim[TRIM_OSC_OFF] && run_s;
   assign supply_fall = sup_d && !sup_s;
   assign supply_rise = !sup_d && sup_s;
   assign acc_start = e_s && !e_d && sup_s;
   assign wr_acc = acc_start && w_s;
   assign rd_acc = acc_start && !w_s;
   assign rd_flags = rd_acc && addr_s == ADDR_FLAGS;

   // Writes to host registers; trim and interrupt setup survive because only reset clears them.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         trim <= TRIM_RESET;
         intr <= INTR_RESET;
         dog_load <= 8'h00;
         load_lock <= 1'b1;
         alarm_sec <= 7'h00;
         alarm_min <= 7'h00;
         alarm_hour <= 7'h00;
         alarm_date <= 7'h00;
         alarm_mask <= 4'h0;
         freq_test <= 1'b0;
         unlock <= 1'b0;
      end else if (wr_acc) begin
         unique case (addr_s)
            ADDR_TRIM: trim <= {din_s[7], 1'b0, din_s[5:0]};
            ADDR_INTR: intr <= {din_s[7:5], 1'b0, din_s[3:2], 2'b00};
            ADDR_DOG: begin
               load_lock <= din_s[DOG_LOCK];
               if (!load_lock && !din_s[DOG_LOCK]) begin
                  dog_load <= {2'b00, din_s[5:0]};
               end
            end
            ADDR_FLAGS: begin
               unlock <= din_s[FLG_UNLOCK];
               if (unlock) begin
                  freq_test <= din_s[FLG_TEST];
               end
            end
            // Seconds and minutes keep a three-bit tens digit, so an alarm at 45 never fires at 05.
            ADDR_ALARM_SEC: if (unlock) {alarm_mask[0], alarm_sec} <= {din_s[7], din_s[6:0]};
            ADDR_ALARM_MIN: if (unlock) {alarm_mask[1], alarm_min} <= {din_s[7], din_s[6:0]};
            ADDR_ALARM_HOUR: if (unlock) {alarm_mask[2], alarm_hour} <= {din_s[7], 1'b0, din_s[5:0]};
            ADDR_ALARM_DATE: if (unlock) {alarm_mask[3], alarm_date} <= {din_s[7], 1'b0, din_s[5:0]};
            default: ;
         endcase
      end
   end

   assign osc_run_en = !trim[TRIM_OSC_OFF];

   // A masked field takes no part; bit 7 of every time input is always zero.
   function automatic logic field_hit(input logic mask, input logic [6:0] alarm, input logic [7:0] now);
      return mask || alarm == now[6:0];
   endfunction : field_hit

   // Every match is gated by the second tick, so even a masked seconds field fires at most once per second.
   assign matched = sec_tick &&
      field_hit(alarm_mask[0], alarm_sec, time_sec) &&
      field_hit(alarm_mask[1], alarm_min, time_min) &&
      field_hit(alarm_mask[2], alarm_hour, time_hour) &&
      field_hit(alarm_mask[3], alarm_date, time_date);

   // Watchdog down-counter.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dog_cnt <= 8'h00;
      end else if (wr_acc && addr_s == ADDR_DOG && din_s[DOG_STROBE]) begin
         dog_cnt <= dog_load;
      end else if (dog_tick && dog_cnt != 8'h00) begin
         dog_cnt <= dog_cnt - 8'h01;
      end
   end
   assign dog_fire = dog_tick && dog_cnt == 8'h01 && dog_load != 8'h00;

   // Oscillator start check after supply returns.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         checking <= 1'b0;
         check_cnt <= 23'h000000;
      end else if (supply_rise && !trim[TRIM_OSC_OFF]) begin
         checking <= 1'b1;
         check_cnt <= 23'h000000;
      end else if (checking) begin
         check_cnt <= check_cnt + 23'h000001;
         if (run_s || check_cnt == 23'(CHECK_CYCLES - 1)) begin
            checking <= 1'b0;
         end
      end
   end

   // Event flags: a new event wins over a clearing read or write in the same cycle.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         osc_fail_flag <= 1'b0;
         alarm_match_flag <= 1'b0;
         dog_timeout_flag <= 1'b0;
         supply_loss_flag <= 1'b0;
         base_time_reload <= 1'b0;
      end else begin
         base_time_reload <= 1'b0;
         if (checking && !run_s && check_cnt == 23'(CHECK_CYCLES - 1)) begin
            osc_fail_flag <= 1'b1;
            base_time_reload <= 1'b1;
         end else if (wr_acc && addr_s == ADDR_FLAGS && unlock && !din_s[FLG_OSC]) begin
            osc_fail_flag <= 1'b0;
         end
         if (matched) begin
            alarm_match_flag <= 1'b1;
         end else if (rd_flags) begin
            alarm_match_flag <= 1'b0;
         end
         if (dog_fire) begin
            dog_timeout_flag <= 1'b1;
         end else if (rd_flags) begin
            dog_timeout_flag <= 1'b0;
         end
         if (supply_fall) begin
            supply_loss_flag <= 1'b1;
         end else if (rd_flags) begin
            supply_loss_flag <= 1'b0;
         end
      end
   end

   // Interrupt drive state.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         int_active <= 1'b0;
         pulse_cnt <= 23'h000000;
      end else if ((matched && intr[INT_ALARM_EN]) || (dog_fire && intr[INT_DOG_EN]) ||
            (supply_fall && intr[INT_SUPPLY_EN])) begin
         int_active <= 1'b1;
         pulse_cnt <= 23'h000000;
      end else if (rd_flags) begin
         int_active <= 1'b0;
      end else if (int_active && intr[INT_PULSE]) begin
         pulse_cnt <= pulse_cnt + 23'h000001;
         if (pulse_cnt == 23'(PULSE_CYCLES - 1)) begin
            int_active <= 1'b0;
         end
      end
   end

   // Pin drive; open-drain mode only pulls low, and the test wave overrides events.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         int_out <= 1'b0;
         int_oe_n <= 1'b1;
      end else if (freq_test) begin
         int_out <= intr[INT_HIGH] ? test_wave : 1'b0;
         int_oe_n <= intr[INT_HIGH] ? 1'b0 : test_wave;
      end else if (intr[INT_HIGH]) begin
         int_out <= int_active && sup_s;
         int_oe_n <= !sup_s;
      end else begin
         int_out <= 1'b0;
         int_oe_n <= !int_active;
      end
   end

   // Read data path.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dq_out <= 8'h00;
         dq_oe_n <= 1'b1;
      end else begin
         dq_oe_n <= !(e_s && g_s && !w_s && sup_s);
         if (rd_acc) begin
            unique case (addr_s)
               ADDR_FLAGS: dq_out <= {dog_timeout_flag, alarm_match_flag, supply_loss_flag, 2'b00,
                  osc_fail_flag, freq_test, unlock};
               ADDR_TRIM: dq_out <= trim;
               ADDR_INTR: dq_out <= intr;
               ADDR_DOG: dq_out <= {1'b0, load_lock, dog_load[5:0]};
               ADDR_ALARM_SEC: dq_out <= {alarm_mask[0], alarm_sec};
               ADDR_ALARM_MIN: dq_out <= {alarm_mask[1], alarm_min};
               ADDR_ALARM_HOUR: dq_out <= {alarm_mask[2], alarm_hour};
               ADDR_ALARM_DATE: dq_out <= {alarm_mask[3], alarm_date};
               default: dq_out <= 8'h00;
            endcase
         end
      end
   end
endmodule : rtw_core

/* core/rtw_pkg.sv */
// Package with register map, field positions and timing constants for the clock support block.
package rtw_pkg;
   localparam logic [14:0] ADDR_FLAGS = 15'h7ff0;
   localparam logic [14:0] ADDR_ALARM_DATE = 15'h7ff5;
   localparam logic [14:0] ADDR_ALARM_HOUR = 15'h7ff4;
   localparam logic [14:0] ADDR_ALARM_MIN = 15'h7ff3;
   localparam logic [14:0] ADDR_ALARM_SEC = 15'h7ff2;
   localparam logic [14:0] ADDR_INTR = 15'h7ff6;
   localparam logic [14:0] ADDR_DOG = 15'h7ff7;
   localparam logic [14:0] ADDR_TRIM = 15'h7ff8;
   // Flags register fields.
   localparam int FLG_DOG = 7;
   localparam int FLG_ALARM = 6;
   localparam int FLG_SUPPLY = 5;
   localparam int FLG_OSC = 2;
   localparam int FLG_TEST = 1;
   localparam int FLG_UNLOCK = 0;
   // Trim register fields.
   localparam int TRIM_OSC_OFF = 7;
   localparam int TRIM_SIGN = 5;
   localparam logic [7:0] TRIM_RESET = 8'h00;
   // Watchdog register fields.
   localparam int DOG_STROBE = 7;
   localparam int DOG_LOCK = 6;
   // Interrupt register fields.
   localparam int INT_DOG_EN = 7;
   localparam int INT_ALARM_EN = 6;
   localparam int INT_SUPPLY_EN = 5;
   localparam int INT_HIGH = 3;
   localparam int INT_PULSE = 2;
   localparam logic [7:0] INTR_RESET = 8'h00;
   // Timing of the 32.768 kHz crystal, in hertz, oscillator cycles, seconds and minutes.
   localparam int OSC_HZ = 32768;
   localparam int DOG_TICK_HZ = 32;
   localparam int DOG_TICK_CYC = OSC_HZ / DOG_TICK_HZ;
   localparam int TEST_HZ = 512;
   localparam int TEST_HALF_CYC = OSC_HZ / (2 * TEST_HZ);
   localparam int TRIM_SHORT_CYC = 128;
   localparam int TRIM_LONG_CYC = 256;
   localparam int TRIM_PERIOD_MIN = 64;
   localparam int TRIM_MAX_MIN = 62;
   localparam int SEC_PER_MIN = 60;
   // Times in their own units, derived system clock counts at 40 MHz and one derived oscillator cycle count.
   localparam int SYS_HZ = 40000000;
   localparam int OSC_CHECK_MS = 5;
   localparam int OSC_CHECK_CYC = (SYS_HZ / 1000) * OSC_CHECK_MS;
   localparam int PULSE_MS = 200;
   localparam int PULSE_CYC = (SYS_HZ / 1000) * PULSE_MS;
   localparam int START_MAX_S = 10;
   localparam int START_TYP_S = 5;
   localparam int START_MAX_OSC = OSC_HZ * START_MAX_S;
endpackage : rtw_pkg

/* core/rtw_sync.sv */
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/1ps
module rtw_sync
   import rtw_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic d,
   output logic q
);
   logic meta;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : rtw_sync

/* core/rtw_trim.sv */
// Oscillator divider with rate trim, watchdog tick and frequency test toggle.
`timescale 1ns/1ps
module rtw_trim
   import rtw_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic osc_edge,
   input wire logic [7:0] trim,
   output logic sec_tick,
   output logic dog_tick,
   output logic test_wave
);
   logic [15:0] sec_cnt;
   logic [5:0] sec_in_min;
   logic [5:0] min_in_period;
   logic [9:0] dog_cnt;
   logic [4:0] test_cnt;
   logic adjust;
   logic [16:0] sec_len;

   // Adjust the first second of each of the first 2N minutes, never past minute 62.
   always_comb begin
      adjust = (sec_in_min == 6'h00) && (trim[4:0] != 5'h00) &&
         ({1'b0, min_in_period} < {1'b0, trim[4:0], 1'b0}) &&
         (min_in_period < 6'(TRIM_MAX_MIN));
      if (!adjust) begin
         sec_len = 17'(OSC_HZ);
      end else if (trim[TRIM_SIGN]) begin
         sec_len = 17'(OSC_HZ - TRIM_SHORT_CYC);
      end else begin
         sec_len = 17'(OSC_HZ + TRIM_LONG_CYC);
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sec_cnt <= 16'h0000;
         sec_in_min <= 6'h00;
         min_in_period <= 6'h00;
         sec_tick <= 1'b0;
      end else begin
         sec_tick <= 1'b0;
         if (osc_edge) begin
            if ({1'b0, sec_cnt} + 17'h00001 >= sec_len) begin
               sec_cnt <= 16'h0000;
               sec_tick <= 1'b1;
               if (sec_in_min == 6'(SEC_PER_MIN - 1)) begin
                  sec_in_min <= 6'h00;
                  min_in_period <= (min_in_period == 6'(TRIM_PERIOD_MIN - 1)) ? 6'h00 : min_in_period + 6'h01;
               end else begin
                  sec_in_min <= sec_in_min + 6'h01;
               end
            end else begin
               sec_cnt <= sec_cnt + 16'h0001;
            end
         end
      end
   end

   // The watchdog and test divider stay untrimmed, so calibration never shifts them.
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         dog_cnt <= 10'h000;
         dog_tick <= 1'b0;
         test_cnt <= 5'h00;
         test_wave <= 1'b0;
      end else begin
         dog_tick <= 1'b0;
         if (osc_edge) begin
            dog_cnt <= (dog_cnt == 10'(DOG_TICK_CYC - 1)) ? 10'h000 : dog_cnt + 10'h001;
            dog_tick <= (dog_cnt == 10'(DOG_TICK_CYC - 1));
            test_cnt <= (test_cnt == 5'(TEST_HALF_CYC - 1)) ? 5'h00 : test_cnt + 5'h01;
            if (test_cnt == 5'(TEST_HALF_CYC - 1)) begin
               test_wave <= ~test_wave;
            end
         end
      end
   end
endmodule : rtw_trim

/* dv/rtw_chk.sv */
// Pin-level assertions for the clock support block.
`timescale 1ns/1ps
module rtw_chk
   import rtw_pkg::*;
#(
   parameter int PULSE_CYCLES = PULSE_CYC,
   parameter int CHECK_CYCLES = OSC_CHECK_CYC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [14:0] addr,
   input wire logic [7:0] dq_in,
   input wire logic [7:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic chip_en_n,
   input wire logic write_en_n,
   input wire logic out_en_n,
   input wire logic osc_clk,
   input wire logic osc_running,
   input wire logic supply_ok,
   input wire logic [7:0] time_sec,
   input wire logic [7:0] time_min,
   input wire logic [7:0] time_hour,
   input wire logic [7:0] time_date,
   input wire logic osc_run_en,
   input wire logic base_time_reload,
   input wire logic int_out,
   input wire logic int_oe_n
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   a_reload_pulse: assert property (base_time_reload |=> !base_time_reload)
      else $error("reload pulse longer than one cycle");
   a_reload_stall: assert property (base_time_reload |-> !$past(osc_running, 3))
      else $error("reload while oscillator running");
   a_reload_enabled: assert property (base_time_reload |-> osc_run_en)
      else $error("reload with oscillator disabled");
   a_backup_quiet: assert property (!supply_ok [*4] |-> dq_oe_n)
      else $error("data driven while on backup");
   a_bus_idle: assert property (chip_en_n [*5] |-> dq_oe_n)
      else $error("data driven while deselected");
   a_dq_on_read: assert property ($changed(dq_out) |-> $past(write_en_n) && !$past(chip_en_n))
      else $error("read data changed without a read");
   a_osc_on_write: assert property ($changed(osc_run_en) |-> !$past(write_en_n))
      else $error("oscillator enable changed without a write");
   a_int_driven: assert property (int_out |-> !int_oe_n)
      else $error("interrupt high while undriven");
   c_reload: cover property (base_time_reload);
   c_int_rise: cover property ($rose(int_out));
   c_read_drive: cover property ($fell(dq_oe_n));
endmodule : rtw_chk

/* dv/rtw_host.sv */
// Bus host model for byte reads and writes on the asynchronous memory bus.
`timescale 1ns/1ps
module rtw_host (
   input wire logic sys_clk,
   input wire logic [7:0] dq_out,
   output logic [14:0] addr,
   output logic [7:0] dq_in,
   output logic chip_en_n,
   output logic write_en_n,
   output logic out_en_n
);
   initial begin
      addr = 15'h0000;
      dq_in = 8'h00;
      chip_en_n = 1'b1;
      write_en_n = 1'b1;
      out_en_n = 1'b1;
   end
   // Held six edges because the block takes the access and loads its answer on the third.
   task automatic acc(input logic w, input logic [14:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge sys_clk);
      addr <= a;
      dq_in <= d;
      write_en_n <= ~w;
      out_en_n <= w;
      chip_en_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      q = dq_out;
      chip_en_n <= 1'b1;
      write_en_n <= 1'b1;
      out_en_n <= 1'b1;
      // Released lines show the inverse, so a late sample cannot pass by luck.
      addr <= ~a;
      dq_in <= ~d;
      repeat (4) @(posedge sys_clk);
   endtask : acc
endmodule : rtw_host

/* dv/test_rtc_trim_alarm_watchdog_irq.sv */
// Bench for the clock support block: register table, test wave, watchdog, supply, oscillator and alarm.
`timescale 1ns/1ps
module test_rtc_trim_alarm_watchdog_irq;
   import rtw_pkg::*;
   typedef struct packed {
      logic w;
      logic [14:0] a;
      logic [7:0] d;
   } rtw_row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic osc_clk = 1'b0;
   logic osc_running = 1'b1;
   logic supply_ok = 1'b1;
   logic [7:0] time_sec = 8'h40;
   logic [14:0] addr;
   logic [7:0] dq_in;
   logic [7:0] dq_out;
   logic dq_oe_n, chip_en_n, write_en_n, out_en_n, osc_run_en, base_time_reload, int_out, int_oe_n;
   int errors = 0;
   int comparisons = 0;
   int n;
   logic last;
   rtw_row_t rows [20] = '{
      '{1'b0, ADDR_TRIM, 8'h00},
      '{1'b1, ADDR_TRIM, 8'h25},
      '{1'b0, ADDR_TRIM, 8'h25},
      '{1'b1, ADDR_FLAGS, 8'h01},
      '{1'b1, ADDR_ALARM_SEC, 8'h40},
      '{1'b1, ADDR_ALARM_MIN, 8'h80},
      '{1'b1, ADDR_ALARM_HOUR, 8'h80},
      '{1'b1, ADDR_ALARM_DATE, 8'h80},
      '{1'b0, ADDR_ALARM_SEC, 8'h40},
      '{1'b1, ADDR_FLAGS, 8'h00},
      '{1'b1, ADDR_ALARM_MIN, 8'h33},
      '{1'b0, ADDR_ALARM_MIN, 8'h80},
      '{1'b1, ADDR_DOG, 8'h02},
      '{1'b1, ADDR_DOG, 8'h02},
      '{1'b1, ADDR_DOG, 8'h42},
      '{1'b0, ADDR_DOG, 8'h42},
      '{1'b1, ADDR_FLAGS, 8'h02},
      '{1'b0, ADDR_FLAGS, 8'h00},
      '{1'b1, ADDR_INTR, 8'h8c},
      '{1'b0, ADDR_INTR, 8'h8c}
   };
   rtw_core #(.PULSE_CYCLES(50), .CHECK_CYCLES(40)) i_dut (
      .time_min(8'h07),
      .time_hour(8'h09),
      .time_date(8'h15),
      .*
   );
   rtw_host i_host (.*);
   always #12.5 sys_clk = ~sys_clk;
   // A fast stand-in crystal keeps one trimmed second inside the run; it stops when disabled.
   always @(posedge sys_clk) if (osc_run_en) osc_clk <= ~osc_clk;
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      logic [7:0] q;
      i_host.acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      logic [7:0] q;
      i_host.acc(1'b0, a, 8'h00, q);
      check($sformatf("reg %h", a), q, e);
   endtask : rd
   // Open-drain mode only ever pulls low, so there the enable is what shows the interrupt.
   task automatic wait_int(input int lim, input logic od);
      for (int k = 0; k < lim && (od ? int_oe_n !== 1'b0 : int_out !== 1'b1); k++) @(negedge sys_clk);
   endtask : wait_int
   task automatic stop_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (90000) @(posedge sys_clk);
      errors++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      check("osc_run_en", {7'h00, osc_run_en}, 8'h01);
      foreach (rows[i]) begin
         if (rows[i].w) wr(rows[i].a, rows[i].d);
         else rd(rows[i].a, rows[i].d);
      end
      $display("table done");
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_FLAGS, 8'h03);
      n = 0;
      last = int_out;
      repeat (1280) begin
         @(negedge sys_clk);
         if (int_out !== last) n++;
         last = int_out;
      end
      check("test_wave", {7'h00, n inside {[19:21]}}, 8'h01);
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_FLAGS, 8'h00);
      $display("test wave done");
      repeat (3) begin
         wr(ADDR_DOG, 8'hc2);
         repeat (1880) @(negedge sys_clk);
         rd(ADDR_FLAGS, 8'h00);
      end
      wait_int(2400, 1'b0);
      check("dog_fire", {7'h00, int_out}, 8'h01);
      repeat (40) @(negedge sys_clk);
      check("pulse_on", {7'h00, int_out}, 8'h01);
      repeat (20) @(negedge sys_clk);
      check("pulse_off", {7'h00, int_out}, 8'h00);
      wr(ADDR_DOG, 8'h00);
      wr(ADDR_DOG, 8'h00);
      wr(ADDR_DOG, 8'hc0);
      rd(ADDR_FLAGS, 8'h80);
      rd(ADDR_FLAGS, 8'h00);
      $display("watchdog done");
      wr(ADDR_INTR, 8'h28);
      supply_ok <= 1'b0;
      repeat (10) @(negedge sys_clk);
      check("supply_int", {6'h00, int_oe_n, int_out}, 8'h02);
      wr(ADDR_TRIM, 8'h80);
      supply_ok <= 1'b1;
      repeat (10) @(negedge sys_clk);
      check("level_hold", {7'h00, int_out}, 8'h01);
      rd(ADDR_TRIM, 8'h25);
      rd(ADDR_FLAGS, 8'h20);
      repeat (4) @(negedge sys_clk);
      check("level_off", {7'h00, int_out}, 8'h00);
      $display("supply done");
      wr(ADDR_INTR, 8'h08);
      osc_running <= 1'b0;
      supply_ok <= 1'b0;
      repeat (10) @(posedge sys_clk);
      supply_ok <= 1'b1;
      n = 0;
      repeat (200) @(negedge sys_clk) if (base_time_reload === 1'b1) n++;
      check("reload", 8'(n), 8'h01);
      check("quiet_pin", {7'h00, int_out}, 8'h00);
      rd(ADDR_FLAGS, 8'h24);
      osc_running <= 1'b1;
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, 8'h04);
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_FLAGS, 8'h00);
      rd(ADDR_FLAGS, 8'h00);
      wr(ADDR_TRIM, 8'ha5);
      check("osc_off", {7'h00, osc_run_en}, 8'h00);
      wr(ADDR_TRIM, 8'h25);
      check("osc_on", {7'h00, osc_run_en}, 8'h01);
      $display("oscillator done");
      wr(ADDR_INTR, 8'h40);
      wait_int(70000, 1'b1);
      check("alarm_int", {6'h00, int_oe_n, int_out}, 8'h00);
      rd(ADDR_FLAGS, 8'h40);
      repeat (4) @(negedge sys_clk);
      check("alarm_clear", {6'h00, int_oe_n, int_out}, 8'h02);
      $display("alarm done");
      stop_test();
   end
endmodule : test_rtc_trim_alarm_watchdog_irq
bind rtw_core rtw_chk #(.PULSE_CYCLES(PULSE_CYCLES), .CHECK_CYCLES(CHECK_CYCLES)) i_chk (.*);
